// File: pkg/codec_defines.svh
// Purpose: register offsets, field positions, reset values and code constants
// Assumes: included by bare name from the codec packages and modules
// Notes: definitions only
`ifndef CODEC_DEFINES_SVH
`define CODEC_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte addresses, low address byte decoded)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_DIV 8'h04
`define REG_STAT 8'h08

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_W 13
`define CTRL_DEC_EN 0
`define CTRL_DEC_DIFF 1
`define CTRL_DEC_SWAP 2
`define CTRL_DEC_SCR 3
`define CTRL_ENC_EN 8
`define CTRL_ENC_DIFF 9
`define CTRL_ENC_SWAP 10
`define CTRL_ENC_SCR 11
`define CTRL_RST 13'h0000
`define DIV_RST 16'h0001

// ----------------------------------------------------------------
// code and scrambler constants
// ----------------------------------------------------------------
`define CONSTRAINT_LEN 7
`define TB_DEPTH 35
`define GEN_FIRST 7'h79
`define GEN_SECOND 7'h5B
`define SCR_HIST_W 20
`define V35_TAP_A 3
`define V35_TAP_B 20
`define SAT_TAP_A 14
`define SAT_TAP_B 15

`endif

// File: pkg/codec_pkg.sv
// Purpose: shared types of the convolutional codec
// Assumes: codec_defines.svh holds all numbers
// Notes: enums carry no explicit codes
`include "codec_defines.svh"
package codec_pkg;

    // ----------------------------------------------------------------
    // modes and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SCR_NONE, SCR_V35, SCR_SAT, SCR_INV2} scr_mode_e;
    typedef enum logic [1:0] {ENC_IDLE, ENC_TAKE, ENC_SECOND} enc_state_e;

    // xor of the scrambler taps for the chosen mode; h[0] is the newest bit
    function automatic logic scr_tap(input scr_mode_e m, input logic [`SCR_HIST_W-1:0] h);
        logic t;
        t = 1'b0;
        if (m == SCR_V35) begin
            t = h[`V35_TAP_A-1] ^ h[`V35_TAP_B-1];
        end else if (m == SCR_SAT) begin
            t = h[`SAT_TAP_A-1] ^ h[`SAT_TAP_B-1];
        end
        return t;
    endfunction

    // first and second generator symbols for {new bit, six older bits}
    function automatic logic [1:0] conv_pair(input logic [`CONSTRAINT_LEN-1:0] v);
        return {^(v & `GEN_FIRST), ^(v & `GEN_SECOND)};
    endfunction

endpackage

// File: hdl/acs_unit.sv
// Purpose: add-compare-select for one trellis state
// Assumes: path metrics wrap; compared by modular difference
// Notes: metric spread stays well under half the metric range
`timescale 1ns/100ps
module acs_unit #(
    parameter int W = 10
) (
    input wire logic [W-1:0] pm0,
    input wire logic [W-1:0] pm1,
    input wire logic [3:0] bm0,
    input wire logic [3:0] bm1,
    output logic [W-1:0] pm,
    output logic sel
);
    logic [W-1:0] c0;
    logic [W-1:0] c1;
    logic [W-1:0] diff;

    // candidate metrics and the smaller survivor; ties keep branch 0
    assign c0 = pm0 + W'(bm0);
    assign c1 = pm1 + W'(bm1);
    assign diff = c0 - c1;
    assign sel = ~diff[W-1] & (|diff);
    assign pm = sel ? c1 : c0;
endmodule // acs_unit

// File: hdl/two_slot_buffer.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: in_ready and out_valid are registered
`timescale 1ns/100ps
module two_slot_buffer #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][W-1:0] data;
        logic [1:0] cnt;
        logic rdy;
        logic vld;
    } buf_s;

    buf_s s;
    buf_s next_s;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // fill and drain
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        push = in_valid & s.rdy;
        pop = s.vld & out_ready;
        if (pop) begin
            next_s.data[0] = s.data[1];
        end
        if (push) begin
            next_s.data[s.cnt - 2'(pop)] = in_data;
        end
        next_s.cnt = s.cnt + 2'(push) - 2'(pop);
        next_s.rdy = (next_s.cnt != 2'h2);
        next_s.vld = (next_s.cnt != 2'h0);
    end

    // register the state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = s.rdy;
    assign out_valid = s.vld;
    assign out_data = s.data[0];
endmodule // two_slot_buffer

// File: hdl/fec_codec.sv
// Purpose: rate one-half K=7 convolutional encoder and Viterbi decoder
// Assumes: AHB-Lite register slave; symbols 0 = strong zero, 7 = strong one
// Notes: register-exchange survivors; output taken from state zero
//        state zero instead of the best state saves a metric search
`timescale 1ns/100ps
`include "codec_defines.svh"
module fec_codec #(
    parameter int DEPTH = `TB_DEPTH,
    parameter int PMW = 10,
    parameter int DIVW = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sym_valid,
    input wire logic [2:0] sym_soft,
    output logic sym_ready,
    output logic dec_valid,
    output logic dec_bit,
    input wire logic dec_ready,
    input wire logic enc_valid,
    input wire logic enc_data,
    output logic enc_ready,
    output logic enc_sym,
    output logic enc_strobe
);
    import codec_pkg::*;

    // one trellis state per six-bit encoder history
    localparam int NS = 64;
    localparam int HW = `SCR_HIST_W;

    typedef struct packed {
        logic [31:0] rdata;
        logic rdy;
        logic resp;
        logic wpend;
        logic [7:0] addr;
        logic [`CTRL_W-1:0] ctrl;
        logic [DIVW-1:0] div;
        logic [DIVW-1:0] cnt;
        enc_state_e est;
        logic ready;
        logic sym;
        logic strobe;
        logic second;
        logic [5:0] sr;
        logic [HW-1:0] ehist;
        logic eprev;
        logic en_d;
        logic [15:0] ecnt;
        logic [2:0] sym0;
        logic half;
        logic [NS-1:0][PMW-1:0] pm;
        logic [NS-1:0][DEPTH-1:0] surv;
        logic [HW-1:0] dhist;
        logic dprev;
        logic den_d;
        logic [15:0] dcnt;
    } state_s;

    localparam state_s S_RST = '{
        rdy: 1'b1,
        ctrl: `CTRL_RST,
        div: DIVW'(`DIV_RST),
        est: ENC_IDLE,
        default: '0
    };

    state_s s;
    state_s next_s;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    logic den;
    logic ddiff;
    logic dswap;
    scr_mode_e dmode;
    logic een;
    logic ediff;
    logic eswap;
    scr_mode_e emode;

    assign den = s.ctrl[`CTRL_DEC_EN];
    assign ddiff = s.ctrl[`CTRL_DEC_DIFF];
    assign dswap = s.ctrl[`CTRL_DEC_SWAP];
    assign dmode = scr_mode_e'(s.ctrl[`CTRL_DEC_SCR+:2]);
    assign een = s.ctrl[`CTRL_ENC_EN];
    assign ediff = s.ctrl[`CTRL_ENC_DIFF];
    assign eswap = s.ctrl[`CTRL_ENC_SWAP];
    assign emode = scr_mode_e'(s.ctrl[`CTRL_ENC_SCR+:2]);

    // ----------------------------------------------------------------
    // soft symbol pairing and branch metrics
    // ----------------------------------------------------------------
    logic take;
    logic [2:0] first_soft;
    logic [2:0] g2_raw;
    logic [2:0] second_soft;
    logic buf_ready;

    // a pair is the held symbol followed by the current one
    assign take = sym_valid & buf_ready;
    assign first_soft = dswap ? sym_soft : s.sym0;
    assign g2_raw = dswap ? s.sym0 : sym_soft;
    assign second_soft = (dmode == SCR_INV2) ? ~g2_raw : g2_raw;

    // distance of the soft pair from an expected symbol pair
    function automatic logic [3:0] bmet(input logic [6:0] v, input logic [2:0] a,
                                        input logic [2:0] b);
        logic [1:0] e;
        logic [2:0] ca;
        logic [2:0] cb;
        e = conv_pair(v);
        ca = e[1] ? ~a : a;
        cb = e[0] ? ~b : b;
        return {1'b0, ca} + {1'b0, cb};
    endfunction

    // ----------------------------------------------------------------
    // trellis: one add-compare-select per state
    // ----------------------------------------------------------------
    logic [NS-1:0] acs_sel;
    logic [NS-1:0][PMW-1:0] acs_pm;

    for (genvar n = 0; n < NS; n++) begin : g_acs
        localparam logic [5:0] P0 = 6'((n * 2) % NS);
        localparam logic [5:0] P1 = P0 | 6'h01;
        localparam logic U = 1'(n / 32);
        logic [3:0] bm0;
        logic [3:0] bm1;

        // branch costs from both predecessors into state n
        assign bm0 = bmet({U, P0}, first_soft, second_soft);
        assign bm1 = bmet({U, P1}, first_soft, second_soft);
        acs_unit #(.W(PMW)) u_acs (
            .pm0(s.pm[P0]),
            .pm1(s.pm[P1]),
            .bm0(bm0),
            .bm1(bm1),
            .pm(acs_pm[n]),
            .sel(acs_sel[n])
        );
    end

    // ----------------------------------------------------------------
    // decoded bit buffer toward the receiver
    // ----------------------------------------------------------------
    logic dec_push;
    logic dec_din;

    two_slot_buffer #(.W(1)) u_dec_buf (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(dec_push),
        .in_data(dec_din),
        .in_ready(buf_ready),
        .out_valid(dec_valid),
        .out_data(dec_bit),
        .out_ready(dec_ready)
    );

    // ----------------------------------------------------------------
    // next-state logic: bus slave, encoder, decoder
    // ----------------------------------------------------------------
    always_comb begin
        logic tick;
        logic y;
        logic z;
        logic [1:0] pr;
        logic g2;
        logic raw;
        logic nrz;
        logic [DEPTH-1:0] pick;
        tick = 1'b0;
        y = 1'b0;
        z = 1'b0;
        pr = 2'h0;
        g2 = 1'b0;
        raw = 1'b0;
        nrz = 1'b0;
        pick = '0;
        next_s = s;
        dec_push = 1'b0;
        dec_din = 1'b0;

        // bus: zero wait states, always OKAY, write lands in data phase
        next_s.rdy = 1'b1;
        next_s.resp = 1'b0;
        next_s.wpend = 1'b0;
        if (s.wpend) begin
            case (s.addr)
                `REG_CTRL: next_s.ctrl = hwdata[`CTRL_W-1:0];
                `REG_DIV: next_s.div = hwdata[DIVW-1:0];
                default: ;
            endcase
        end
        if (hsel && htrans[1] && hready) begin
            next_s.wpend = hwrite;
            next_s.addr = haddr[7:0];
            // read data uses values updated by a write just finishing
            case (haddr[7:0])
                `REG_CTRL: next_s.rdata = {{(32 - `CTRL_W){1'b0}}, next_s.ctrl};
                `REG_DIV: next_s.rdata = {{(32 - DIVW){1'b0}}, next_s.div};
                `REG_STAT: next_s.rdata = {s.ecnt, s.dcnt};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // encoder symbol-rate divider
        tick = (s.cnt == '0);
        next_s.cnt = tick ? s.div : s.cnt - 1'b1;

        // encoder: one bit in, two symbols out at tick rate when enabled, one plain symbol out when disabled
        next_s.strobe = 1'b0;
        next_s.en_d = een;
        unique case (s.est)
            ENC_IDLE: begin
                if (tick) begin
                    next_s.ready = 1'b1;
                    next_s.est = ENC_TAKE;
                end
            end
            ENC_TAKE: begin
                if (enc_valid) begin
                    next_s.ready = 1'b0;
                    next_s.ecnt = s.ecnt + 16'h0001;
                    next_s.strobe = 1'b1;
                    if (!een) begin
                        next_s.sym = enc_data;
                        next_s.est = ENC_IDLE;
                    end else begin
                        y = enc_data ^ scr_tap(emode, s.ehist);
                        next_s.ehist = {s.ehist[HW-2:0], y};
                        z = ediff ? (y ^ s.eprev) : y;
                        next_s.eprev = z;
                        pr = conv_pair({z, s.sr});
                        next_s.sr = {z, s.sr[5:1]};
                        g2 = pr[0] ^ (emode == SCR_INV2);
                        next_s.sym = eswap ? g2 : pr[1];
                        next_s.second = eswap ? pr[1] : g2;
                        next_s.est = ENC_SECOND;
                    end
                end
            end
            ENC_SECOND: begin
                if (tick) begin
                    next_s.sym = s.second;
                    next_s.strobe = 1'b1;
                    next_s.est = ENC_IDLE;
                end
            end
            // two-bit state code 3 is never entered
            default: begin
                next_s.est = ENC_IDLE; // unused code falls back to idle
            end
        endcase

        // encoder starts from the zero state when enabled
        if (een && !s.en_d) begin
            next_s.sr = '0;
            next_s.ehist = '0;
            next_s.eprev = 1'b0;
        end

        // decoder: symbols discarded while disabled
        next_s.den_d = den;
        if (den && !s.den_d) begin
            next_s.pm = '0;
            next_s.surv = '0;
            next_s.half = 1'b0;
            next_s.dhist = '0;
            next_s.dprev = 1'b0;
        end else if (den && take) begin
            if (!s.half) begin
                next_s.sym0 = sym_soft;
                next_s.half = 1'b1;
            end else begin
                // second symbol of the pair: one trellis step, one bit out
                next_s.half = 1'b0;
                next_s.pm = acs_pm;
                for (int n = 0; n < NS; n++) begin
                    pick = acs_sel[n] ? s.surv[(n * 2 + 1) % NS] : s.surv[(n * 2) % NS];
                    next_s.surv[n] = {pick[DEPTH-2:0], n >= 32};
                end
                // oldest bit of state zero; survivors have merged by this depth
                raw = s.surv[0][DEPTH-1];
                nrz = ddiff ? (raw ^ s.dprev) : raw;
                next_s.dprev = raw;
                dec_din = nrz ^ scr_tap(dmode, s.dhist);
                next_s.dhist = {s.dhist[HW-2:0], nrz};
                dec_push = 1'b1;
                next_s.dcnt = s.dcnt + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata = s.rdata;
    assign hreadyout = s.rdy;
    assign hresp = s.resp;
    // symbol ready and decoded bits come from the buffer's own flops
    assign sym_ready = buf_ready;
    assign enc_ready = s.ready;
    assign enc_sym = s.sym;
    assign enc_strobe = s.strobe;
endmodule // fec_codec

// File: verification/codec_assertions.sv
// Purpose: port-level checks of fec_codec
// Assumes: one clock, hready fed back from hreadyout
// Notes: shadows control and divider writes to predict reads
`timescale 1ns/100ps
module codec_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic dec_valid,
    input wire logic dec_bit,
    input wire logic dec_ready,
    input wire logic enc_valid,
    input wire logic enc_data,
    input wire logic enc_ready,
    input wire logic enc_sym,
    input wire logic enc_strobe
);
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    logic pv, pw, seen, en_last;
    logic [7:0] pa;
    logic [12:0] ctrl;
    logic [15:0] div;
    logic [1:0] off_cnt;
    logic [3:0] nstr;
    logic [31:0] rd_exp;
    wire logic take = enc_valid && enc_ready;
    // register shadow, idle count of decoder, strobes since last take
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {pv, pw, seen, en_last, pa, nstr, off_cnt} <= '0;
            ctrl <= 13'h0000;
            div <= 16'h0001;
        end else begin
            pv <= hsel && htrans[1] && hready;
            pw <= hwrite;
            pa <= haddr[7:0];
            if (pv && pw && pa == 8'h00) ctrl <= hwdata[12:0];
            if (pv && pw && pa == 8'h04) div <= hwdata[15:0];
            off_cnt <= ctrl[0] ? 2'h0 : (off_cnt == 2'h3 ? 2'h3 : off_cnt + 2'h1);
            nstr <= take ? 4'h0 : nstr + {3'h0, enc_strobe};
            seen <= seen || take;
            en_last <= take ? ctrl[8] : en_last;
        end
    end
    // predicted read data of the data phase
    always_comb rd_exp = pa == 8'h00 ? {19'h0, ctrl} : (pa == 8'h04 ? {16'h0, div} : 32'h0);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_take; enc_valid && enc_ready; endsequence
    sequence s_first; enc_strobe && !enc_ready; endsequence
    property p_okay; hreadyout && !hresp; endproperty
    property p_reset; $rose(hresetn) |-> !dec_valid && !enc_ready && !enc_strobe; endproperty
    property p_enc_take; s_take |=> s_first; endproperty
    property p_plain; s_take ##0 !ctrl[8] |=> enc_sym == $past(enc_data); endproperty
    property p_pairs; s_take ##0 (seen && en_last == ctrl[8]) |-> nstr == (ctrl[8] ? 2 : 1);
    endproperty
    property p_sym_hold; !enc_strobe |-> $stable(enc_sym); endproperty
    property p_dec_hold; dec_valid && !dec_ready |=> dec_valid && $stable(dec_bit); endproperty
    property p_dec_off; off_cnt == 2'h3 && !dec_valid |=> !dec_valid; endproperty
    property p_read; pv && !pw && pa != 8'h08 |-> hrdata == rd_exp; endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
    a_reset: assert property (p_reset) else $error("outputs busy after reset");
    a_enc_take: assert property (p_enc_take) else $error("no symbol after take");
    a_plain: assert property (p_plain) else $error("plain bit not passed");
    a_pairs: assert property (p_pairs) else $error("wrong symbols per bit");
    a_sym_hold: assert property (p_sym_hold) else $error("symbol moved without strobe");
    a_dec_hold: assert property (p_dec_hold) else $error("decoded bit dropped");
    a_dec_off: assert property (p_dec_off) else $error("output while disabled");
    a_read: assert property (p_read) else $error("register read mismatch");
endmodule // codec_assertions

bind fec_codec codec_assertions chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dec_valid(dec_valid),
    .dec_bit(dec_bit), .dec_ready(dec_ready), .enc_valid(enc_valid), .enc_data(enc_data),
    .enc_ready(enc_ready), .enc_sym(enc_sym), .enc_strobe(enc_strobe));

// File: verification/remote_encoder.sv
// Purpose: far-end encoder feeding soft symbols to the decoder
// Assumes: mode bit0 differential, bit1 swap, bits 3:2 scrambler code
// Notes: strong soft values with rare flipped symbols; logs sent bits
`timescale 1ns/100ps
module remote_encoder (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [3:0] mode,
    input wire logic [31:0] rnd,
    input wire logic sym_ready,
    output logic sym_valid,
    output logic [2:0] sym_soft
);
    logic [6:0] sr;
    logic m, second, b, y;
    logic [19:0] h;
    logic [1:0] g, pr;
    bit sent[$];
    // offer one symbol, hold it until taken, stop only at a pair boundary
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sym_valid <= 1'b0;
            sym_soft <= 3'h5;
            {sr, m, second, pr, h} = '0;
        end else if (!sym_valid || sym_ready) begin
            if (second || run) begin
                if (!second) begin
                    y = rnd[0] ^ (mode[3:2] == 2'h1 ? h[2] ^ h[19]
                        : (mode[3:2] == 2'h2 ? h[13] ^ h[14] : 1'b0));
                    h = {h[18:0], y};
                    m = mode[0] ? m ^ y : y;
                    sent.push_back(rnd[0]);
                    sr = {m, sr[6:1]};
                    g = {^(sr & 7'h79), ^(sr & 7'h5B)} ^ {1'b0, mode[3:2] == 2'h3};
                    pr = mode[1] ? {g[0], g[1]} : g;
                end
                b = second ? pr[0] : pr[1];
                sym_soft <= (b ? 3'h6 : 3'h0) ^ {2'h0, rnd[1]}
                    ^ (rnd[11:4] == 8'h00 ? 3'h7 : 3'h0);
                sym_valid <= 1'b1;
                second = !second;
            end else begin
                sym_valid <= 1'b0;
                sym_soft <= rnd[14:12];
            end
        end
    end
endmodule // remote_encoder

// File: verification/testbench.sv
// Purpose: self-checking bench of fec_codec
// Assumes: hreadyout is fed back as hready
// Notes: bench model of the encoder; decoder checked against far-end log
`timescale 1ns/100ps
module testbench;
    logic hclk, hresetn, hsel, hwrite, dec_ready, enc_valid, enc_data, run, stall;
    logic [31:0] haddr, hwdata, rnd, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, sym_soft;
    logic [3:0] mode;
    logic hreadyout, hresp, sym_valid, sym_ready, dec_valid, dec_bit, enc_ready, enc_sym;
    logic enc_strobe;
    int n_errors = 0;
    int check_count = 0;
    int low_seen;
    logic got[$], eq[$];
    bit exp[$];
    fec_codec DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sym_valid(sym_valid),
        .sym_soft(sym_soft), .sym_ready(sym_ready), .dec_valid(dec_valid), .dec_bit(dec_bit),
        .dec_ready(dec_ready), .enc_valid(enc_valid), .enc_data(enc_data),
        .enc_ready(enc_ready), .enc_sym(enc_sym), .enc_strobe(enc_strobe));
    remote_encoder far (.hclk(hclk), .hresetn(hresetn), .run(run), .mode(mode), .rnd(rnd),
        .sym_ready(sym_ready), .sym_valid(sym_valid), .sym_soft(sym_soft));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // noise source, receiver stalls, output capture
    always @(posedge hclk) begin
        rnd <= xs(rnd);
        dec_ready <= !stall || rnd[4:2] == 3'h0;
        if (dec_valid && dec_ready) got.push_back(dec_bit);
        if (enc_strobe) eq.push_back(enc_sym);
        if (stall && !sym_ready) low_seen++;
    end
    task automatic check(string what, logic [31:0] e, logic [31:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic bus(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (!hreadyout);
        rd = hrdata;
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(string n, logic [31:0] a, logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(n, e, r);
    endtask
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        got.delete();
        eq.delete();
        far.sent.delete();
        @(posedge hclk);
    endtask
    task automatic enc_run(logic [31:0] c, int n);
        logic [6:0] sr;
        logic m, d, y;
        logic [1:0] g;
        logic [19:0] h;
        do_reset();
        {sr, m, h} = '0;
        exp.delete();
        wr(32'h0, c);
        repeat (4) @(posedge hclk);
        repeat (n) begin
            d = rnd[5];
            enc_valid <= 1'b1;
            enc_data <= d;
            do @(posedge hclk); while (!enc_ready);
            y = d ^ (c[12:11] == 2'h1 ? h[2] ^ h[19]
                : (c[12:11] == 2'h2 ? h[13] ^ h[14] : 1'b0));
            h = {h[18:0], y};
            m = c[9] ? m ^ y : y;
            sr = {m, sr[6:1]};
            g = {^(sr & 7'h79), ^(sr & 7'h5B)} ^ {1'b0, c[12:11] == 2'h3};
            if (c[10]) g = {g[0], g[1]};
            if (c[8]) exp.push_back(g[1]);
            exp.push_back(c[8] ? g[0] : d);
        end
        enc_valid <= 1'b0;
        repeat (20) @(posedge hclk);
        check("enc count", exp.size(), eq.size());
        foreach (exp[i]) check("enc sym", exp[i], eq[i]);
        rd("stat enc", 32'h8, {n[15:0], 16'h0});
        $display("encoder test %h done", c);
    endtask
    task automatic dec_run(logic [31:0] c, int n, logic st);
        do_reset();
        wr(32'h0, c);
        mode <= {c[4:3], c[2], c[1]};
        stall <= st;
        low_seen = 0;
        repeat (4) @(posedge hclk);
        run <= 1'b1;
        while (far.sent.size() < n) @(negedge hclk);
        run <= 1'b0;
        repeat (100) @(posedge hclk);
        stall <= 1'b0;
        repeat (60) @(posedge hclk);
        check("dec count", c[0] ? n : 0, got.size());
        for (int k = 35; k < got.size(); k++) check("dec bit", far.sent[k - 35], got[k]);
        rd("stat dec", 32'h8, c[0] ? n : 0);
        if (st) check("full refuse", 32'h1, {31'h0, low_seen > 0});
        $display("decoder test %h done", c);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (60000) @(posedge hclk);
        n_errors++;
        $display("Error watchdog expected done seen timeout");
        wrap_up();
    end
    // main sequence
    initial begin
        {hsel, hwrite, enc_valid, enc_data, run, stall, dec_ready} = '0;
        {haddr, hwdata, htrans, mode} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        rnd = 32'h0000_7EDA;
        do_reset();
        rd("ctrl", 32'h0, 32'h0);
        rd("div", 32'h4, 32'h1);
        wr(32'h0, 32'hFFFF_FFFF);
        rd("ctrl", 32'h0, 32'h1FFF);
        wr(32'h4, 32'hFFFF_FFFF);
        rd("div", 32'h4, 32'hFFFF);
        wr(32'hC, 32'h5);
        rd("unmapped", 32'hC, 32'h0);
        wr(32'h8, 32'h1234);
        rd("stat", 32'h8, 32'h0);
        $display("register test done");
        enc_run(32'h1E00, 30);
        enc_run(32'h0100, 40);
        enc_run(32'h0300, 40);
        enc_run(32'h0500, 40);
        enc_run(32'h1900, 40);
        enc_run(32'h0900, 20);
        enc_run(32'h1100, 20);
        dec_run(32'h01, 150, 1'b0);
        dec_run(32'h03, 150, 1'b0);
        dec_run(32'h05, 150, 1'b1);
        dec_run(32'h19, 150, 1'b0);
        dec_run(32'h09, 150, 1'b0);
        dec_run(32'h13, 150, 1'b0);
        dec_run(32'h00, 40, 1'b0);
        wrap_up();
    end
endmodule // testbench
